// file: hw/cpu_bus_ctl.sv
// Control core: timing counter, program counter, index and stack
// registers, status, interrupt and reset sequencing, ready halt.
// Assumes: pins arrive asynchronous; decode supplies op info per fetch.
//
// Notes on behaviour
// - Cycle counter clears on each fetch and steps each phase one.
// - Fetch puts counter low byte on low address, high on upper; then increments.
// - Two 8-bit index registers; selected one is added to base address.
// - 8-bit stack pointer moves down on pushes automatically.
// - 8-bit status register with seven flags, program or processor set.
// - 16-bit address bus floats when bus enable is low.
// - Bus enable high drives address and read/write; data only on writes.
// - Data drivers off in reads; data enable gates data output.
// - Data bus floats when either bus enable or data enable is low.
// - Maskable request sampled in phase two when mask clear; pushes counter, status.
// - Maskable entry sets mask; vector from FFFE low, FFFF high.
// - Interrupts recognised only while ready is high.
// - Memory lock low during modify and write cycles of read-modify-write.
// - Non-maskable falling edge sampled phase two; vector FFFA low, FFFB high.
// - Non-maskable is edge triggered; held level gives no new interrupt.
// - Phase one output is inverse of phase two output.
// - Phase four is delayed phase two; address valid before it rises.
// - Ready low at phase one halts with address held while ready stays low.
// - Reset release runs six-cycle init then loads vector FFFC, FFFD.
// - Init writes old counter and status to stack, sets mask, clears decimal.
// - Read/write high for reads, low for writes, floats with bus enable low.
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_ctl (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic reset_in_n_i,
  input wire logic irq_n_i,
  input wire logic nmi_n_i,
  input wire logic ready_i,
  input wire logic bus_drive_enable_i,
  input wire logic data_drive_enable_i,
  input wire logic [7:0] data_bus_i,
  input wire logic [2:0] op_cycles_i,
  input wire cpu_ctl_pkg::op_kind_t op_kind_i,
  input wire logic [1:0] index_sel_i,
  input wire logic index_load_i,
  input wire logic [7:0] index_load_val_i,
  input wire logic [7:0] status_set_i,
  input wire logic [7:0] status_clr_i,
  input wire logic [15:0] operand_addr_i,
  input wire logic [7:0] write_data_i,
  output logic [15:0] addr_bus_o,
  output logic addr_bus_oe_o,
  output logic rd_wr_o,
  output logic rd_wr_oe_o,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe_o,
  output logic memory_lock_n_o,
  output logic phi1_o,
  output logic phi2_o,
  output logic phi4_o,
  output logic [2:0] cycle_count_o,
  output logic [15:0] prog_counter_o,
  output logic [7:0] index_x_o,
  output logic [7:0] index_y_o,
  output logic [7:0] stack_ptr_o,
  output logic [7:0] status_o,
  output logic fetch_o,
  output logic halted_o
);
  typedef enum logic [2:0] {ST_RESET_LOW, ST_INIT, ST_VEC_LO, ST_VEC_HI, ST_FETCH, ST_EXEC,
    ST_INT_PUSH, ST_INT_VEC} seq_state_t;
  function automatic logic [15:0] stack_addr(input logic [7:0] sp);
    stack_addr = cpu_ctl_pkg::STACK_PAGE | {8'h00, sp};
  endfunction
  bus_drv_if drv ();
  logic phi1_start;
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic rst_n_s;
  logic irq_n_s;
  logic nmi_n_s;
  logic ready_s;
  logic nmi_prev_ff;
  logic nmi_pend_ff;
  logic irq_pend_ff;
  logic rst_prev_ff;
  logic [2:0] rst_low_ff;
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [2:0] cycle_ff;
  logic [2:0] step_ff;
  logic [15:0] pc_ff;
  logic [7:0] x_ff;
  logic [7:0] y_ff;
  logic [7:0] sp_ff;
  logic [7:0] status_ff;
  logic [15:0] vec_base_ff;
  cpu_ctl_pkg::op_kind_t kind_ff;
  logic [2:0] need_ff;
  logic [15:0] eff_addr_ff;
  logic [7:0] idx_val;
  logic halt;
  logic adv;
  phase_gen u_phase (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .phi1_o(phi1_o),
    .phi2_o(phi2_o),
    .phi4_o(phi4_o),
    .phi1_start_o(phi1_start)
  );
  bus_pins u_pins (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .req(drv.pins),
    .bus_drive_enable_i(bus_drive_enable_i),
    .data_drive_enable_i(data_drive_enable_i),
    .addr_bus_o(addr_bus_o),
    .addr_bus_oe_o(addr_bus_oe_o),
    .rd_wr_o(rd_wr_o),
    .rd_wr_oe_o(rd_wr_oe_o),
    .data_bus_o(data_bus_o),
    .data_bus_oe_o(data_bus_oe_o),
    .memory_lock_n_o(memory_lock_n_o)
  );
  // Two-stage synchronisers for pin inputs
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 5'h1f;
      sync2_ff <= 5'h1f;
    end
    else if (ce_i)
    begin
      sync1_ff <= {reset_in_n_i, irq_n_i, nmi_n_i, ready_i, 1'b1};
      sync2_ff <= sync1_ff;
    end
  end
  assign rst_n_s = sync2_ff[4];
  assign irq_n_s = sync2_ff[3];
  assign nmi_n_s = sync2_ff[2];
  assign ready_s = sync2_ff[1];
  // Ready low seen at a phase-one start stalls; phase two keeps stall while low
  assign halt = ~ready_s & (state_ff != ST_RESET_LOW);
  assign adv = phi1_start & ~halt;
  assign halted_o = halt;
  // Interrupt capture in phase two
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      nmi_prev_ff <= 1'b1;
      nmi_pend_ff <= 1'b0;
      irq_pend_ff <= 1'b0;
    end
    else if (ce_i && phi2_o)
    begin
      nmi_prev_ff <= nmi_n_s;
      if (nmi_prev_ff && !nmi_n_s && ready_s)
        nmi_pend_ff <= 1'b1;
      else if (adv && state_ff == ST_INT_VEC && vec_base_ff == cpu_ctl_pkg::NMI_VEC_LO)
        nmi_pend_ff <= 1'b0;
      irq_pend_ff <= ~irq_n_s & ~status_ff[cpu_ctl_pkg::FLAG_IMASK] & ready_s;
    end
  end
  // Reset pin edge and hold-time tracking
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rst_prev_ff <= 1'b0;
      rst_low_ff <= 3'h0;
    end
    else if (ce_i && phi1_start)
    begin
      rst_prev_ff <= rst_n_s;
      if (rst_n_s)
        rst_low_ff <= 3'h0;
      else if (rst_low_ff != cpu_ctl_pkg::RST_MIN_LOW_CYCLES)
        rst_low_ff <= rst_low_ff + 3'h1;
    end
  end
  assign idx_val = index_sel_i[1] ? y_ff : (index_sel_i[0] ? x_ff : 8'h00);
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET_LOW: if (rst_n_s && !rst_prev_ff && rst_low_ff == cpu_ctl_pkg::RST_MIN_LOW_CYCLES)
        nxt_state = ST_INIT;
      ST_INIT: if (step_ff == cpu_ctl_pkg::RST_INIT_CYCLES - 3'h1)
        nxt_state = ST_VEC_LO;
      ST_VEC_LO: nxt_state = ST_VEC_HI;
      ST_VEC_HI: nxt_state = ST_FETCH;
      ST_FETCH: nxt_state = (op_cycles_i > 3'h1) ? ST_EXEC : ST_FETCH;
      ST_EXEC: if (cycle_ff + 3'h1 >= need_ff)
        nxt_state = (nmi_pend_ff || irq_pend_ff) ? ST_INT_PUSH : ST_FETCH;
      ST_INT_PUSH: if (step_ff == 3'h2)
        nxt_state = ST_INT_VEC;
      ST_INT_VEC: if (step_ff == 3'h1)
        nxt_state = ST_FETCH;
      default: nxt_state = ST_RESET_LOW;
    endcase
    if (!rst_n_s && rst_low_ff == cpu_ctl_pkg::RST_MIN_LOW_CYCLES)
      nxt_state = ST_RESET_LOW;
  end
  // Sequencer state, timing counter and step counter
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_RESET_LOW;
      cycle_ff <= 3'h0;
      step_ff <= 3'h0;
      need_ff <= 3'h1;
      kind_ff <= cpu_ctl_pkg::OP_NONE;
      eff_addr_ff <= 16'h0000;
    end
    else if (ce_i && adv)
    begin
      state_ff <= nxt_state;
      step_ff <= (nxt_state != state_ff) ? 3'h0 : step_ff + 3'h1;
      cycle_ff <= (nxt_state == ST_FETCH) ? 3'h0 : cycle_ff + 3'h1;
      if (state_ff == ST_FETCH)
      begin
        need_ff <= op_cycles_i;
        kind_ff <= op_kind_i;
        eff_addr_ff <= operand_addr_i + {8'h00, idx_val};
      end
    end
  end
  // Program counter, vector base, stack pointer and status
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pc_ff <= cpu_ctl_pkg::PC_RESET;
      sp_ff <= cpu_ctl_pkg::SP_RESET;
      status_ff <= cpu_ctl_pkg::STATUS_RESET;
      vec_base_ff <= cpu_ctl_pkg::RST_VEC_LO;
    end
    else if (ce_i && adv)
    begin
      case (state_ff)
        ST_INIT:
        begin
          if (step_ff < 3'h3)
            sp_ff <= sp_ff - 8'h01;
          status_ff[cpu_ctl_pkg::FLAG_IMASK] <= 1'b1;
          status_ff[cpu_ctl_pkg::FLAG_DECIMAL] <= 1'b0;
        end
        ST_VEC_LO: pc_ff[7:0] <= data_bus_i;
        ST_VEC_HI: pc_ff[15:8] <= data_bus_i;
        ST_FETCH: pc_ff <= pc_ff + 16'h0001;
        ST_EXEC:
        begin
          status_ff <= ((status_ff | status_set_i) & ~status_clr_i) | cpu_ctl_pkg::STATUS_FIXED;
          if (nxt_state == ST_INT_PUSH)
            vec_base_ff <= nmi_pend_ff ? cpu_ctl_pkg::NMI_VEC_LO : cpu_ctl_pkg::IRQ_VEC_LO;
        end
        ST_INT_PUSH:
        begin
          sp_ff <= sp_ff - 8'h01;
          if (step_ff == 3'h2)
            status_ff[cpu_ctl_pkg::FLAG_IMASK] <= 1'b1;
        end
        ST_INT_VEC:
          if (step_ff == 3'h0)
            pc_ff[7:0] <= data_bus_i;
          else
            pc_ff[15:8] <= data_bus_i;
        default: pc_ff <= pc_ff;
      endcase
    end
  end
  // Index registers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      x_ff <= 8'h00;
      y_ff <= 8'h00;
    end
    else if (ce_i && adv && index_load_i)
    begin
      if (index_sel_i[1])
        y_ff <= index_load_val_i;
      else
        x_ff <= index_load_val_i;
    end
  end
  // Bus request; held unchanged while halted so the address stays put
  always_comb
  begin
    drv.addr = pc_ff;
    drv.wdata = (step_ff == 3'h0) ? pc_ff[15:8] :
      ((step_ff == 3'h1) ? pc_ff[7:0] : status_ff);
    drv.write = 1'b0;
    drv.lock = 1'b0;
    case (state_ff)
      ST_INIT:
      begin
        drv.addr = stack_addr(sp_ff);
        drv.write = (step_ff < 3'h3);
      end
      ST_VEC_LO: drv.addr = cpu_ctl_pkg::RST_VEC_LO;
      ST_VEC_HI: drv.addr = cpu_ctl_pkg::RST_VEC_HI;
      ST_FETCH: drv.addr = pc_ff;
      ST_EXEC:
      begin
        drv.addr = eff_addr_ff;
        drv.write = (kind_ff == cpu_ctl_pkg::OP_WRITE) ||
          (kind_ff == cpu_ctl_pkg::OP_RMW && cycle_ff + 3'h1 == need_ff);
        drv.lock = (kind_ff == cpu_ctl_pkg::OP_RMW) && (cycle_ff + 3'h2 >= need_ff);
        drv.wdata = write_data_i;
      end
      ST_INT_PUSH:
      begin
        drv.addr = stack_addr(sp_ff);
        drv.write = 1'b1;
      end
      ST_INT_VEC: drv.addr = vec_base_ff | {15'h0000, step_ff[0]};
      default: drv.addr = pc_ff;
    endcase
  end
  assign cycle_count_o = cycle_ff;
  assign prog_counter_o = pc_ff;
  assign index_x_o = x_ff;
  assign index_y_o = y_ff;
  assign stack_ptr_o = sp_ff;
  assign status_o = status_ff;
  assign fetch_o = (state_ff == ST_FETCH);
endmodule
`default_nettype wire

// file: hw/cpu_ctl_pkg.sv
// Package: constants for the bus, interrupt and reset control block
// Assumes: all other files reference it as cpu_ctl_pkg::name
package cpu_ctl_pkg;
  localparam logic [15:0] NMI_VEC_LO = 16'hfffa;
  localparam logic [15:0] NMI_VEC_HI = 16'hfffb;
  localparam logic [15:0] RST_VEC_LO = 16'hfffc;
  localparam logic [15:0] RST_VEC_HI = 16'hfffd;
  localparam logic [15:0] IRQ_VEC_LO = 16'hfffe;
  localparam logic [15:0] IRQ_VEC_HI = 16'hffff;
  localparam logic [15:0] STACK_PAGE = 16'h0100;
  localparam logic [2:0] RST_INIT_CYCLES = 3'h6;
  localparam logic [2:0] RST_MIN_LOW_CYCLES = 3'h2;
  localparam logic [7:0] SP_RESET = 8'hfd;
  localparam logic [7:0] STATUS_RESET = 8'h34;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_ZERO = 1;
  localparam int FLAG_IMASK = 2;
  localparam int FLAG_DECIMAL = 3;
  localparam int FLAG_BRK = 4;
  localparam int FLAG_ONE = 5;
  localparam int FLAG_OVF = 6;
  localparam int FLAG_NEG = 7;
  localparam logic [7:0] STATUS_FIXED = 8'h20;
  typedef enum logic [1:0] {OP_NONE, OP_READ, OP_RMW, OP_WRITE} op_kind_t;
endpackage

// file: hw/bus_drv_if.sv
// Interface: bus request from the sequencer to the pin driver
// Assumes: one clock domain, sequencer drives, pin driver consumes
`timescale 1ns/10ps
`default_nettype none
interface bus_drv_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic write;
  logic lock;
  modport seq (output addr, output wdata, output write, output lock);
  modport pins (input addr, input wdata, input write, input lock);
endinterface
`default_nettype wire

// file: hw/phase_gen.sv
// Phase clock generator: phase two toggles every enabled cycle
// Assumes: ce_i gates all state; phase one is the inverse of phase two
`timescale 1ns/10ps
`default_nettype none
module phase_gen (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  output logic phi1_o,
  output logic phi2_o,
  output logic phi4_o,
  output logic phi1_start_o
);
  logic phi2_ff;
  logic phi4_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      phi2_ff <= 1'b0;
      phi4_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      phi2_ff <= ~phi2_ff;
      phi4_ff <= phi2_ff;
    end
  end

  assign phi2_o = phi2_ff;
  assign phi1_o = ~phi2_ff;
  assign phi4_o = phi4_ff;
  assign phi1_start_o = ce_i & phi2_ff;
endmodule
`default_nettype wire

// file: hw/bus_pins.sv
// Pin driver: three-state address, read/write and data outputs
// Assumes: the enclosing chip resolves the wires from the enables
`timescale 1ns/10ps
`default_nettype none
module bus_pins (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  bus_drv_if.pins req,
  input wire logic bus_drive_enable_i,
  input wire logic data_drive_enable_i,
  output logic [15:0] addr_bus_o,
  output logic addr_bus_oe_o,
  output logic rd_wr_o,
  output logic rd_wr_oe_o,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe_o,
  output logic memory_lock_n_o
);
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      addr_bus_o <= 16'h0000;
      rd_wr_o <= 1'b1;
      data_bus_o <= 8'h00;
      memory_lock_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      addr_bus_o <= req.addr;
      rd_wr_o <= ~req.write;
      data_bus_o <= req.wdata;
      memory_lock_n_o <= ~req.lock;
    end
  end

  assign addr_bus_oe_o = bus_drive_enable_i;
  assign rd_wr_oe_o = bus_drive_enable_i;
  assign data_bus_oe_o = bus_drive_enable_i & data_drive_enable_i & ~rd_wr_o;
endmodule
`default_nettype wire

// file: tb/cpu_bus_ctl_assertions.sv
// Checker: port timing relations of the control core
// Assumes: bound to cpu_bus_ctl, one clock, rst_i active high
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_ctl_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic bus_drive_enable_i,
  input wire logic data_drive_enable_i,
  input wire logic [15:0] addr_bus_o,
  input wire logic addr_bus_oe_o,
  input wire logic rd_wr_o,
  input wire logic rd_wr_oe_o,
  input wire logic data_bus_oe_o,
  input wire logic memory_lock_n_o,
  input wire logic phi1_o,
  input wire logic phi2_o,
  input wire logic phi4_o,
  input wire logic [2:0] cycle_count_o,
  input wire logic [7:0] stack_ptr_o,
  input wire logic [7:0] status_o,
  input wire logic halted_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  a_phase_one_inv: assert property (phi1_o == !phi2_o)
    else $error("phase one wrong");
  a_phase_four_lag: assert property
    (!$past(rst_i) |-> phi4_o == $past(phi2_o))
    else $error("phase four wrong");
  a_addr_float_be: assert property
    (addr_bus_oe_o == bus_drive_enable_i && rd_wr_oe_o == bus_drive_enable_i)
    else $error("address drive wrong");
  a_data_drive_gate: assert property
    (data_bus_oe_o == (bus_drive_enable_i && data_drive_enable_i && !rd_wr_o))
    else $error("data drive wrong");
  a_halt_holds_addr: assert property
    (halted_o && $past(halted_o) && $past(halted_o, 2) |-> $stable(addr_bus_o))
    else $error("address moved in halt");
  a_stack_step: assert property
    ($changed(stack_ptr_o) |-> stack_ptr_o == $past(stack_ptr_o) + 8'h1
      || stack_ptr_o == $past(stack_ptr_o) - 8'h1)
    else $error("stack jump");
  a_cycle_step: assert property
    ($changed(cycle_count_o) |-> cycle_count_o == 3'h0
      || cycle_count_o == $past(cycle_count_o) + 3'h1)
    else $error("cycle count jump");
  a_reset_vec_pair: assert property
    ($changed(addr_bus_o) && addr_bus_o == cpu_ctl_pkg::RST_VEC_HI
      |-> $past(addr_bus_o) == cpu_ctl_pkg::RST_VEC_LO)
    else $error("reset vector order");
  a_nmi_vec_pair: assert property
    ($rose(addr_bus_o == cpu_ctl_pkg::NMI_VEC_LO)
      |-> ##[1:12] addr_bus_o == cpu_ctl_pkg::NMI_VEC_HI)
    else $error("nmi vector order");
  a_irq_mask_set: assert property
    ($changed(addr_bus_o) && addr_bus_o == cpu_ctl_pkg::IRQ_VEC_LO
      |-> status_o[cpu_ctl_pkg::FLAG_IMASK])
    else $error("mask not set");
  a_lock_addr_hold: assert property
    (!memory_lock_n_o |-> $stable(addr_bus_o))
    else $error("lock with moving address");
endmodule
bind cpu_bus_ctl cpu_bus_ctl_checker chk (.sys_clk_i, .rst_i, .bus_drive_enable_i,
  .data_drive_enable_i, .addr_bus_o, .addr_bus_oe_o, .rd_wr_o, .rd_wr_oe_o, .data_bus_oe_o,
  .memory_lock_n_o, .phi1_o, .phi2_o, .phi4_o, .cycle_count_o, .stack_ptr_o, .status_o,
  .halted_o);
`default_nettype wire

// file: tb/bus_mem_model.sv
// Partner: memory on the far side of the bus, with slow ready
// Assumes: device bus outputs change on sys_clk_i edges
`timescale 1ns/10ps
`default_nettype none
module bus_mem_model (
  input wire logic sys_clk_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wdata_oe_i,
  input wire logic slow_i,
  output logic [7:0] rdata_o,
  output logic ready_o
);
  logic [7:0] mem [65536];
  logic [15:0] last_ff = 16'h0000;
  logic [1:0] wait_ff = 2'h0;
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    mem[16'hfffb] = 8'h03;
    mem[16'hfffd] = 8'h02;
    mem[16'hffff] = 8'h04;
  end
  assign ready_o = !(slow_i && wait_ff != 2'h0);
  // Asynchronous read: data follows the address within the same bus cycle
  assign rdata_o = rd_wr_i ? mem[addr_i] : 8'hff;
  always @(posedge sys_clk_i)
  begin
    if (!rd_wr_i && wdata_oe_i)
      mem[addr_i] <= wdata_i;
    last_ff <= addr_i;
    wait_ff <= (addr_i != last_ff) ? 2'h2 : wait_ff - {1'b0, wait_ff != 2'h0};
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Testbench: control core against the bus memory model
// Assumes: package, design, checker and model compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rn = 1'b0, irq = 1'b1, nmi = 1'b1, be = 1'b1, dbe = 1'b1, slow = 1'b0, ild = 1'b0;
  logic [2:0] ncyc = 3'h2;
  cpu_ctl_pkg::op_kind_t kind = cpu_ctl_pkg::OP_READ;
  logic [1:0] isel = 2'h0;
  logic [7:0] ival = 8'h00, sclr = 8'h00, wd = 8'h00, sset = 8'h00;
  logic [15:0] opa = 16'h1000;
  logic [15:0] addr, a0, pcv;
  logic [7:0] dout, din, sp, st, ix, iy, s0;
  logic [2:0] cnt;
  logic rw, aoe, doe, lock, fetch, hlt, rdy, ok;
  int n_fail = 0, samples_checked = 0, cyc = 0, nhalt = 0;
  cpu_bus_ctl uut (.sys_clk_i, .rst_i, .ce_i(1'b1), .reset_in_n_i(rn), .irq_n_i(irq),
    .nmi_n_i(nmi), .ready_i(rdy), .bus_drive_enable_i(be), .data_drive_enable_i(dbe),
    .data_bus_i(din), .op_cycles_i(ncyc), .op_kind_i(kind), .index_sel_i(isel),
    .index_load_i(ild), .index_load_val_i(ival), .status_set_i(sset), .status_clr_i(sclr),
    .operand_addr_i(opa), .write_data_i(wd), .addr_bus_o(addr), .addr_bus_oe_o(aoe),
    .rd_wr_o(rw), .rd_wr_oe_o(), .data_bus_o(dout), .data_bus_oe_o(doe),
    .memory_lock_n_o(lock), .phi1_o(), .phi2_o(), .phi4_o(), .cycle_count_o(cnt),
    .prog_counter_o(pcv), .index_x_o(ix), .index_y_o(iy), .stack_ptr_o(sp), .status_o(st),
    .fetch_o(fetch), .halted_o(hlt));
  bus_mem_model mdl (.sys_clk_i, .addr_i(addr), .rd_wr_i(rw), .wdata_i(dout),
    .wdata_oe_i(doe), .slow_i(slow), .rdata_o(din), .ready_o(rdy));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ck(int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wa(logic [15:0] a, logic r, int n, output logic f);
    f = 1'b0;
    for (int i = 0; i < n && !f; i++)
    begin
      @(negedge sys_clk_i);
      f = (addr === a && rw === r);
    end
  endtask
  task automatic wf;
    logic p;
    p = 1'b1;
    for (int i = 0; i < 80 && !(fetch === 1'b1 && !p); i++)
    begin
      p = (fetch === 1'b1);
      @(negedge sys_clk_i);
    end
    @(negedge sys_clk_i);
  endtask
  task automatic tend(string n);
    $display("test %s done", n);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
    forever #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (hlt === 1'b1)
      nhalt++;
    if (cyc == 20000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    ck(16);
    rst_i = 1'b0;
    ck(10);
    rn = 1'b1;
    wa(cpu_ctl_pkg::RST_VEC_LO, 1'b1, 40, ok);
    chk("reset vector", 16'h1, {15'h0, ok});
    wf;
    chk("reset start", 16'h0200, addr);
    chk("reset counter", 16'h0200, pcv);
    chk("init stack", {8'h0, cpu_ctl_pkg::SP_RESET - 8'h3}, {8'h0, sp});
    chk("init flags", 16'h4, {8'h0, st & 8'h0c});
    chk("pushed status", {8'h0, cpu_ctl_pkg::STATUS_RESET}, {8'h0, mdl.mem[16'h01fb]});
    tend("reset");
    kind = cpu_ctl_pkg::OP_NONE;
    wf;
    a0 = addr;
    wf;
    chk("next fetch", a0 + 16'h1, addr);
    chk("count at fetch", 16'h0, {13'h0, cnt});
    tend("fetch");
    kind = cpu_ctl_pkg::OP_READ;
    for (int k = 0; k < 2; k++)
    begin
      isel = k ? 2'h2 : 2'h1;
      ival = k ? 8'h05 : 8'h81;
      opa = 16'h1000;
      ild = 1'b1;
      wf;
      wf;
      ild = 1'b0;
      opa = 16'h12f0;
      wa(16'h12f0 + {8'h0, ival}, 1'b1, 30, ok);
      chk("indexed access", 16'h1, {15'h0, ok});
    end
    chk("index x", 16'h0081, {8'h0, ix});
    chk("index y", 16'h0005, {8'h0, iy});
    tend("index");
    isel = 2'h0;
    kind = cpu_ctl_pkg::OP_WRITE;
    opa = 16'h0350;
    wd = 8'h5a;
    wa(16'h0350, 1'b0, 30, ok);
    chk("write cycle", 16'h1, {15'h0, ok});
    chk("write drive", 16'h1, {15'h0, doe});
    ck(1);
    dbe = 1'b0;
    be = 1'b0;
    ck(1);
    chk("data gated", 16'h0, {15'h0, doe});
    chk("address float", 16'h0, {15'h0, aoe});
    dbe = 1'b1;
    be = 1'b1;
    chk("written byte", 16'h005a, {8'h0, mdl.mem[16'h0350]});
    tend("write");
    kind = cpu_ctl_pkg::OP_RMW;
    ncyc = 3'h5;
    opa = 16'h0040;
    wa(16'h0040, 1'b0, 40, ok);
    chk("rmw write", 16'h1, {15'h0, ok});
    chk("lock in write", 16'h0, {15'h0, lock});
    kind = cpu_ctl_pkg::OP_READ;
    ncyc = 3'h2;
    wf;
    wf;
    chk("lock released", 16'h1, {15'h0, lock});
    tend("rmw");
    slow = 1'b1;
    wf;
    a0 = addr;
    wf;
    chk("fetch after stall", a0 + 16'h1, addr);
    chk("halt seen", 16'h1, {15'h0, nhalt > 0});
    slow = 1'b0;
    tend("ready");
    irq = 1'b0;
    wa(cpu_ctl_pkg::IRQ_VEC_LO, 1'b1, 40, ok);
    chk("masked request", 16'h0, {15'h0, ok});
    sclr = 8'h04;
    wf;
    sclr = 8'h00;
    s0 = sp;
    wa(cpu_ctl_pkg::IRQ_VEC_LO, 1'b1, 60, ok);
    chk("irq taken", 16'h1, {15'h0, ok});
    irq = 1'b1;
    wf;
    chk("irq handler", 16'h0400, addr);
    chk("irq pushes", {8'h0, s0 - 8'h3}, {8'h0, sp});
    chk("irq mask", 16'h4, {8'h0, st & 8'h04});
    sset = 8'h01;
    wf;
    sset = 8'h00;
    chk("status set", 16'h0021, {8'h0, st & 8'h21});
    tend("irq");
    nmi = 1'b0;
    wa(cpu_ctl_pkg::NMI_VEC_LO, 1'b1, 60, ok);
    chk("nmi taken", 16'h1, {15'h0, ok});
    wf;
    chk("nmi handler", 16'h0300, addr);
    wa(cpu_ctl_pkg::NMI_VEC_LO, 1'b1, 60, ok);
    chk("nmi level", 16'h0, {15'h0, ok});
    nmi = 1'b1;
    ck(6);
    nmi = 1'b0;
    wa(cpu_ctl_pkg::NMI_VEC_LO, 1'b1, 60, ok);
    chk("nmi new edge", 16'h1, {15'h0, ok});
    tend("nmi");
    close_out();
  end
endmodule
`default_nettype wire
